// [core/ahch_pkg.sv]
package ahch_pkg;
    // Register byte offsets on the APB side
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_P0 = 8'h04;
    localparam logic [7:0] REG_P1 = 8'h08;
    localparam logic [7:0] REG_ISSUE = 8'h0C;
    localparam logic [7:0] REG_SCODE = 8'h10;
    localparam logic [7:0] REG_SP0 = 8'h14;
    localparam logic [7:0] REG_BURST = 8'h18;
    localparam logic [7:0] REG_OPT = 8'h1C;
    localparam logic [7:0] REG_GRP = 8'h20;
    // Command codes
    localparam logic [15:0] CODE_ERRLOG = 16'h000A;
    localparam logic [15:0] CODE_READ = 16'h000B;
    localparam logic [15:0] CODE_MODOPT = 16'h000D;
    localparam logic [15:0] CODE_RESOPT = 16'h000E;
    localparam logic [15:0] CODE_GRPHI = 16'h000F;
    localparam logic [15:0] CODE_BRIDGE = 16'h0010;
    // Completion values
    localparam logic [15:0] ST_GOOD = 16'h8000;
    localparam logic [15:0] ST_BADOPT = 16'h0100;
    localparam logic [15:0] OPT_VALID_MASK = 16'hFFFF;
    localparam logic [15:0] GRP_HI_RST = 16'hC000;
    localparam logic [15:0] ADDR_CLR_MASK = 16'h7FFF;
    localparam logic [15:0] FAULT_LO = 16'h0200;
    localparam logic [15:0] FAULT_HI = 16'h02FE;
    localparam logic [7:0] BURST_RST = 8'h08;
    localparam logic [2:0] ERRLOG_LAST = 3'h6;
    localparam logic [2:0] AREA_LAST = 3'h1;
    localparam logic [2:0] BBLK_LAST = 3'h3;
    // Bridge option fields and limits
    localparam int BOPT_BCAST = 0;
    localparam int BOPT_LEN_LSB = 6;
    localparam int BOPT_PART_LSB = 12;
    localparam logic [5:0] RIF_MIN = 6'h06;
    localparam logic [5:0] RIF_MAX = 6'h1E;
    localparam logic [3:0] PART_MAX = 4'hE;
    localparam int BST_GOOD = 0;
    localparam int BST_LEN = 1;
    localparam int BST_SRC = 2;
    localparam int BST_TGT = 3;
    localparam int BST_BRG = 4;
    localparam int BST_OPT = 5;
    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_EXEC, S_MEMRD, S_MEMWT, S_MEMCAP, S_WRITE, S_DONE
    } ahch_state_t;
endpackage

// [core/ahch_route_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ahch_route_if;
    logic enable;
    logic bcast_all;
    logic [5:0] max_len;
    logic [3:0] part_len;
    logic [15:0] src_ring;
    logic [15:0] tgt_ring;
    logic [15:0] brg_num;
    modport cfg (output enable, bcast_all, max_len, part_len, src_ring, tgt_ring, brg_num);
    modport flt (input enable, bcast_all, max_len, part_len, src_ring, tgt_ring, brg_num);
endinterface
`default_nettype wire

// [core/ahch_route_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module ahch_route_filter (
    input wire logic clk_i,
    input wire logic rst_i,
    ahch_route_if.flt cfg,
    input wire logic frm_valid_i,
    input wire logic frm_bcast_i,
    input wire logic frm_single_i,
    input wire logic [5:0] frm_len_i,
    input wire logic [15:0] frm_seg_in_i,
    input wire logic [15:0] frm_seg_out_i,
    output logic fwd_o,
    output logic rej_o
);
    function automatic logic [15:0] ring_of(input logic [15:0] seg, input logic [3:0] p);
        ring_of = 16'(seg >> p);
    endfunction
    function automatic logic [15:0] brg_of(input logic [15:0] seg, input logic [3:0] p);
        brg_of = seg & ~16'(16'hFFFF << p);
    endfunction

    wire too_long = frm_len_i > cfg.max_len;
    wire at_max = frm_len_i == cfg.max_len;
    wire in_ok = ring_of(frm_seg_in_i, cfg.part_len) == cfg.src_ring;
    wire brg_ok = brg_of(frm_seg_in_i, cfg.part_len) == cfg.brg_num;
    wire out_ok = ring_of(frm_seg_out_i, cfg.part_len) == cfg.tgt_ring;
    wire bc_rej = frm_bcast_i & (at_max | (frm_single_i & ~cfg.bcast_all));
    wire rt_rej = frm_bcast_i ? ~in_ok : ~(in_ok & brg_ok & out_ok);
    wire rej_w = ~cfg.enable | too_long | bc_rej | rt_rej;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_o <= 1'b0;
            rej_o <= 1'b0;
        end else begin
            fwd_o <= frm_valid_i & ~rej_w;
            rej_o <= frm_valid_i & rej_w;
        end
    end

    chk_single_bcast: assert property (@(posedge clk_i) disable iff (rst_i)
        frm_valid_i && frm_bcast_i && frm_single_i && !cfg.bcast_all |=> rej_o && !fwd_o)
        else $error("single-route broadcast forwarded");
    chk_rif_length: assert property (@(posedge clk_i) disable iff (rst_i)
        frm_valid_i && frm_len_i > cfg.max_len |=> rej_o)
        else $error("over-length routing field forwarded");
    cov_forward: cover property (@(posedge clk_i) disable iff (rst_i) fwd_o);
endmodule // ahch_route_filter
`default_nettype wire

// [core/ahch_cmd_handler.sv]
// Function
// - Error-log readout completes with done interrupt, code 000A, status 8000; dropped silently when not open.
// - Memory readout 000B uses two words as host pointer; completes 8000.
// - Readout data uses the receive DMA method and burst size.
// - Host area gives byte count and address; address bit 15 cleared.
// - Readout of undefined storage raises adapter-check instead of completing.
// - Reads of 0200 to 02FE fault; 0100 to 01FE should be avoided.
// - Modify options 000D applies all bits except wrap bit 0.
// - Restore 000E equals modify; both rejected when not open.
// - Options commands complete with 8000, or 0100 for invalid option.
// - Group high is C000 after open; 000F replaces it, status 8000.
// - Group high stored by 000F has bit 0 forced to one; reset and open values stay C000.
// - Bridge command 0010 needs open; parameters point to block.
// - Broadcast bit clear rejects single-route, keeps all-routes broadcasts; the filter also rejects every broadcast whose length equals the maximum.
// - Max routing length bits 6-11, even, 6 to 30; limits frames.
// - Partition length bits 12-15; zero or above 14 invalid.
// - Source and target rings nonzero, in range, and different.
// - Bridge number from zero to partition maximum, compared per segment.
// - Bridge error disables the checker; still done with code 0010.
// - Bridge status bit-coded: bit 0 good, bit 1 bad length.
`timescale 1ns/1ps
`default_nettype none
module ahch_cmd_handler (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Adapter state
    input wire logic OPEN_I,
    input wire logic [15:0] OPEN_OPT_I,
    input wire logic [111:0] ERR_CNT_I,
    output logic ERR_CLR_O,
    output logic [15:0] OPEN_OPT_O,
    output logic [15:0] GRP_HI_O,
    // Adapter memory read
    output logic MEM_RD_O,
    output logic [15:0] MEM_ADDR_O,
    input wire logic [15:0] MEM_RDATA_I,
    // Host DMA
    output logic DMA_REQ_O,
    output logic DMA_WE_O,
    output logic [31:0] DMA_ADDR_O,
    output logic [15:0] DMA_WDATA_O,
    input wire logic [15:0] DMA_RDATA_I,
    input wire logic DMA_ACK_I,
    // Host interrupts
    output logic CMD_DONE_O,
    output logic CMD_REJ_O,
    output logic ADP_CHK_O,
    // Route checker
    output logic SRC_CHK_EN_O,
    input wire logic FRM_VALID_I,
    input wire logic FRM_BCAST_I,
    input wire logic FRM_SINGLE_I,
    input wire logic [5:0] FRM_LEN_I,
    input wire logic [15:0] FRM_SEG_IN_I,
    input wire logic [15:0] FRM_SEG_OUT_I,
    output logic FRM_FWD_O,
    output logic FRM_REJ_O
);
    import ahch_pkg::*;

    ahch_state_t st_q;
    logic [15:0] cmd_q, p0_q, p1_q, scode_q, sp0_q, sts_q, opt_q, grp_q, madr_q, cnt_q;
    logic [15:0] buf_q [0:3];
    logic [31:0] ptr_q, prdata_q;
    logic [7:0] burst_q, bcnt_q;
    logic [2:0] idx_q, last_q;
    logic pready_q, pslverr_q, open_q, dreq_q, we_q, mrd_q, done_q, rej_q, chk_q, clr_q, en_q;
    logic [15:0] wdata_q;
    logic [31:0] rsel;
    logic map_ok;

    ahch_route_if rif();

    // APB: one wait state, so read data and error come from flops
    wire apb_acc = PSEL_I & PENABLE_I & ~pready_q;
    wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I & pready_q & ~pslverr_q;
    wire busy = st_q != S_IDLE;
    wire a_issue = PADDR_I == REG_ISSUE;
    wire issue_w = apb_wr & a_issue & ~busy;

    always_comb begin
        rsel = 32'h0000_0000;
        map_ok = 1'b1;
        if (PADDR_I == REG_CMD) begin
            rsel = {16'h0000, cmd_q};
        end else if (PADDR_I == REG_P0) begin
            rsel = {16'h0000, p0_q};
        end else if (PADDR_I == REG_P1) begin
            rsel = {16'h0000, p1_q};
        end else if (PADDR_I == REG_ISSUE) begin
            rsel = {31'h0000_0000, busy};
        end else if (PADDR_I == REG_SCODE) begin
            rsel = {16'h0000, scode_q};
        end else if (PADDR_I == REG_SP0) begin
            rsel = {16'h0000, sp0_q};
        end else if (PADDR_I == REG_BURST) begin
            rsel = {24'h00_0000, burst_q};
        end else if (PADDR_I == REG_OPT) begin
            rsel = {16'h0000, opt_q};
        end else if (PADDR_I == REG_GRP) begin
            rsel = {16'h0000, grp_q};
        end else begin
            map_ok = 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc & ~map_ok;
            prdata_q <= (apb_acc & ~PWRITE_I) ? rsel : 32'h0000_0000;
        end
    end

    // Command block words; locked while a command runs
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cmd_q <= 16'h0000;
            p0_q <= 16'h0000;
            p1_q <= 16'h0000;
            burst_q <= BURST_RST;
        end else if (apb_wr & ~busy) begin
            if (PADDR_I == REG_CMD) cmd_q <= PWDATA_I[15:0];
            if (PADDR_I == REG_P0) p0_q <= PWDATA_I[15:0];
            if (PADDR_I == REG_P1) p1_q <= PWDATA_I[15:0];
            if (PADDR_I == REG_BURST) burst_q <= (PWDATA_I[7:0] == 8'h00) ? 8'h01 : PWDATA_I[7:0];
        end
    end

    // Command classes
    wire is_opt = (cmd_q == CODE_MODOPT) | (cmd_q == CODE_RESOPT);
    wire needs_open = is_opt | (cmd_q == CODE_GRPHI) | (cmd_q == CODE_BRIDGE);
    wire known = needs_open | (cmd_q == CODE_ERRLOG) | (cmd_q == CODE_READ);
    wire bad_opt = |(p0_q & ~OPT_VALID_MASK);
    wire open_rise = OPEN_I & ~open_q;
    wire [31:0] host_ptr = {p0_q, p1_q};
    wire fault_w = (madr_q >= FAULT_LO) & (madr_q <= FAULT_HI);
    wire [15:0] rd_words = 16'((17'(buf_q[0]) + 17'h00001) >> 1);

    // Bridge block check: options, source, target, bridge number
    wire [15:0] b_opt = buf_q[0];
    wire [5:0] b_len = b_opt[BOPT_LEN_LSB +: 6];
    wire [3:0] b_part = b_opt[BOPT_PART_LSB +: 4];
    wire [15:0] ring_max = 16'(16'hFFFF >> b_part);
    wire [15:0] brg_max = ~16'(16'hFFFF << b_part);
    wire e_len = b_len[0] | (b_len < RIF_MIN) | (b_len > RIF_MAX);
    wire e_same = buf_q[1] == buf_q[2];
    wire e_src = (buf_q[1] == 16'h0000) | (buf_q[1] > ring_max) | e_same;
    wire e_tgt = (buf_q[2] == 16'h0000) | (buf_q[2] > ring_max) | e_same;
    wire e_brg = buf_q[3] > brg_max;
    wire e_opt = (b_part == 4'h0) | (b_part > PART_MAX);
    wire [15:0] bst_w = {10'h000, e_opt, e_brg, e_tgt, e_src, e_len,
        ~(e_opt | e_brg | e_tgt | e_src | e_len)};

    // DMA word handshake shared by every transfer
    wire ack = dreq_q & DMA_ACK_I;
    wire last_w = (st_q == S_FETCH) ? (idx_q == last_q) : (cnt_q == 16'h0001);
    wire burst_end = bcnt_q == 8'(burst_q - 8'h01);
    wire keep_req = ~burst_end & ~last_w & ((st_q == S_FETCH) | (cmd_q == CODE_ERRLOG));

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_q <= S_IDLE;
            open_q <= 1'b0;
            opt_q <= 16'h0000;
            grp_q <= GRP_HI_RST;
            scode_q <= 16'h0000;
            sp0_q <= 16'h0000;
            sts_q <= 16'h0000;
            ptr_q <= 32'h0000_0000;
            madr_q <= 16'h0000;
            cnt_q <= 16'h0000;
            idx_q <= 3'h0;
            last_q <= 3'h0;
            bcnt_q <= 8'h00;
            dreq_q <= 1'b0;
            we_q <= 1'b0;
            wdata_q <= 16'h0000;
            mrd_q <= 1'b0;
            done_q <= 1'b0;
            rej_q <= 1'b0;
            chk_q <= 1'b0;
            clr_q <= 1'b0;
            en_q <= 1'b0;
            for (int i = 0; i < 4; i++) buf_q[i] <= 16'h0000;
        end else begin
            open_q <= OPEN_I;
            done_q <= 1'b0;
            rej_q <= 1'b0;
            chk_q <= 1'b0;
            clr_q <= 1'b0;
            mrd_q <= 1'b0;
            if (open_rise) begin
                grp_q <= GRP_HI_RST;
                opt_q <= OPEN_OPT_I;
            end
            case (st_q)
                S_IDLE: begin
                    bcnt_q <= 8'h00;
                    idx_q <= 3'h0;
                    ptr_q <= host_ptr;
                    if (issue_w) begin
                        if (~known | (needs_open & ~OPEN_I)) begin
                            rej_q <= 1'b1;
                        end else if (cmd_q == CODE_ERRLOG) begin
                            // Not open: command dropped silently
                            if (OPEN_I) begin
                                cnt_q <= {13'h0000, ERRLOG_LAST} + 16'h0001;
                                we_q <= 1'b1;
                                wdata_q <= ERR_CNT_I[15:0];
                                dreq_q <= 1'b1;
                                st_q <= S_WRITE;
                            end
                        end else if (cmd_q == CODE_READ || cmd_q == CODE_BRIDGE) begin
                            last_q <= (cmd_q == CODE_READ) ? AREA_LAST : BBLK_LAST;
                            we_q <= 1'b0;
                            dreq_q <= 1'b1;
                            st_q <= S_FETCH;
                        end else begin
                            st_q <= S_EXEC;
                        end
                    end
                end
                S_FETCH: begin
                    if (ack) begin
                        buf_q[idx_q[1:0]] <= DMA_RDATA_I;
                        idx_q <= idx_q + 3'h1;
                        ptr_q <= ptr_q + 32'h0000_0002;
                        bcnt_q <= keep_req ? 8'(bcnt_q + 8'h01) : 8'h00;
                        dreq_q <= keep_req;
                        if (last_w) st_q <= S_EXEC;
                    end else begin
                        dreq_q <= 1'b1;
                    end
                end
                S_EXEC: begin
                    st_q <= S_DONE;
                    sts_q <= ST_GOOD;
                    if (cmd_q == CODE_READ) begin
                        madr_q <= buf_q[1] & ADDR_CLR_MASK;
                        cnt_q <= rd_words;
                        ptr_q <= host_ptr;
                        bcnt_q <= 8'h00;
                        if (rd_words != 16'h0000) st_q <= S_MEMRD;
                    end else if (is_opt) begin
                        if (bad_opt) begin
                            sts_q <= ST_BADOPT;
                        end else begin
                            opt_q <= {p0_q[15:1], opt_q[0]};
                        end
                    end else if (cmd_q == CODE_GRPHI) begin
                        grp_q <= {p0_q[15:1], 1'b1};
                    end else begin
                        sts_q <= bst_w;
                        en_q <= bst_w == 16'h0001;
                    end
                end
                S_MEMRD: begin
                    if (fault_w) begin
                        chk_q <= 1'b1;
                        st_q <= S_IDLE;
                    end else begin
                        mrd_q <= 1'b1;
                        st_q <= S_MEMWT;
                    end
                end
                S_MEMWT: st_q <= S_MEMCAP;
                S_MEMCAP: begin
                    wdata_q <= MEM_RDATA_I;
                    we_q <= 1'b1;
                    dreq_q <= 1'b1;
                    st_q <= S_WRITE;
                end
                S_WRITE: begin
                    if (ack) begin
                        ptr_q <= ptr_q + 32'h0000_0002;
                        cnt_q <= cnt_q - 16'h0001;
                        idx_q <= idx_q + 3'h1;
                        bcnt_q <= (keep_req | ~burst_end) ? 8'(bcnt_q + 8'h01) : 8'h00;
                        dreq_q <= keep_req;
                        wdata_q <= ERR_CNT_I[16 * (idx_q + 3'h1) +: 16];
                        if (last_w) begin
                            sts_q <= ST_GOOD;
                            st_q <= S_DONE;
                        end else if (cmd_q == CODE_READ) begin
                            madr_q <= madr_q + 16'h0002;
                            st_q <= S_MEMRD;
                        end
                    end else begin
                        dreq_q <= 1'b1;
                    end
                end
                S_DONE: begin
                    we_q <= 1'b0;
                    dreq_q <= 1'b0;
                    scode_q <= cmd_q;
                    sp0_q <= sts_q;
                    done_q <= 1'b1;
                    clr_q <= cmd_q == CODE_ERRLOG;
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign rif.enable = en_q;
    assign rif.bcast_all = buf_q[0][BOPT_BCAST];
    assign rif.max_len = b_len;
    assign rif.part_len = b_part;
    assign rif.src_ring = buf_q[1];
    assign rif.tgt_ring = buf_q[2];
    assign rif.brg_num = buf_q[3];

    ahch_route_filter u_filter (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .cfg(rif.flt),
        .frm_valid_i(FRM_VALID_I),
        .frm_bcast_i(FRM_BCAST_I),
        .frm_single_i(FRM_SINGLE_I),
        .frm_len_i(FRM_LEN_I),
        .frm_seg_in_i(FRM_SEG_IN_I),
        .frm_seg_out_i(FRM_SEG_OUT_I),
        .fwd_o(FRM_FWD_O),
        .rej_o(FRM_REJ_O)
    );

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign ERR_CLR_O = clr_q;
    assign OPEN_OPT_O = opt_q;
    assign GRP_HI_O = grp_q;
    assign MEM_RD_O = mrd_q;
    assign MEM_ADDR_O = madr_q;
    assign DMA_REQ_O = dreq_q;
    assign DMA_WE_O = we_q;
    assign DMA_ADDR_O = ptr_q;
    assign DMA_WDATA_O = wdata_q;
    assign CMD_DONE_O = done_q;
    assign CMD_REJ_O = rej_q;
    assign ADP_CHK_O = chk_q;
    assign SRC_CHK_EN_O = en_q;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    chk_errlog_done: assert property (
        CMD_DONE_O && scode_q == CODE_ERRLOG |-> sp0_q == ST_GOOD && ERR_CLR_O)
        else $error("error log completion wrong");
    chk_fetch_ptr: assert property (
        st_q == S_FETCH && idx_q == 3'h0 && dreq_q |-> DMA_ADDR_O == host_ptr)
        else $error("host pointer not used");
    chk_burst_cap: assert property (
        dreq_q |-> bcnt_q < burst_q)
        else $error("burst length exceeded");
    chk_addr_bit15: assert property (
        MEM_RD_O |-> !MEM_ADDR_O[15])
        else $error("address bit 15 not cleared");
    chk_fault_irq: assert property (
        st_q == S_MEMRD && fault_w |=> ADP_CHK_O && !MEM_RD_O ##1 !CMD_DONE_O)
        else $error("fault area did not raise adapter check");
    chk_wrap_kept: assert property (
        st_q == S_EXEC && is_opt && !open_rise |=> OPEN_OPT_O[0] == $past(OPEN_OPT_O[0]))
        else $error("wrap bit modified");
    chk_reject_closed: assert property (
        issue_w && needs_open && !OPEN_I |=> CMD_REJ_O && st_q == S_IDLE ##1 !CMD_DONE_O)
        else $error("closed-adapter command not rejected");
    chk_opt_status: assert property (
        st_q == S_EXEC && is_opt |=> ##1 CMD_DONE_O && sp0_q == (bad_opt ? ST_BADOPT : ST_GOOD))
        else $error("options status wrong");
    chk_grp_open: assert property (
        $rose(OPEN_I) && !busy |=> GRP_HI_O == GRP_HI_RST)
        else $error("group high not reset on open");
    chk_grp_bit0: assert property (
        st_q == S_EXEC && cmd_q == CODE_GRPHI && !open_rise |=> GRP_HI_O == {$past(p0_q[15:1]), 1'b1})
        else $error("group high bit 0 not forced");
    chk_bridge_err: assert property (
        CMD_DONE_O && scode_q == CODE_BRIDGE |-> SRC_CHK_EN_O == (sp0_q == 16'h0001))
        else $error("checker enable disagrees with status");

    cov_readout: cover property (CMD_DONE_O && scode_q == CODE_READ);
    cov_bridge_bad: cover property (CMD_DONE_O && scode_q == CODE_BRIDGE && !SRC_CHK_EN_O);
    cov_reject: cover property (CMD_REJ_O);
endmodule // ahch_cmd_handler
`default_nettype wire

// [verification/ahch_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ahch_host_model (
    // Host DMA side
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic ack_o
);
    logic [15:0] mem [256];
    logic [15:0] last_q;
    // Slow host: ack only every other cycle
    always @(posedge clk_i) begin
        ack_o <= req_i & (ack_o !== 1'b1);
        if (req_i & ack_o & we_i)
            mem[addr_i[8:1]] <= wdata_i;
        if (req_i & ack_o)
            last_q <= rdata_o;
    end
    // Stale data never repeats the last word
    assign rdata_o = ack_o ? mem[addr_i[8:1]] : ~last_q;
endmodule // ahch_host_model
`default_nettype wire

// [verification/adapter_host_command_handler_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adapter_host_command_handler_bench;
    import ahch_pkg::*;
    logic CLK_I = 0, RST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, OPEN_I = 1, clr = 1, err;
    logic FRM_VALID_I = 0, FRM_BCAST_I = 0, FRM_SINGLE_I = 0, PREADY_O, PSLVERR_O, ERR_CLR_O, MEM_RD_O;
    logic DMA_REQ_O, DMA_WE_O, DMA_ACK_I, CMD_DONE_O, CMD_REJ_O, ADP_CHK_O, SRC_CHK_EN_O, FRM_FWD_O, FRM_REJ_O;
    logic [7:0] PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, DMA_ADDR_O, rd;
    logic [15:0] OPEN_OPT_I = 16'h0, OPEN_OPT_O, GRP_HI_O, MEM_ADDR_O, MEM_RDATA_I, DMA_WDATA_O, DMA_RDATA_I;
    logic [15:0] FRM_SEG_IN_I = 16'h0, FRM_SEG_OUT_I = 16'h0;
    logic [111:0] ERR_CNT_I = 112'h1106_1105_1104_1103_1102_1101_1100;
    logic [5:0] FRM_LEN_I = 6'h14;
    logic [3:0] ev;
    int n_mismatch = 0, checked = 0, cyc = 0;
    // Code, param0, open, events (1 done, 2 reject), register, value
    logic [15:0] rows [7][6] = '{'{CODE_GRPHI, 16'h1234, 16'h1, 16'h1, REG_GRP, 16'h1235},
        '{CODE_MODOPT, 16'hEFFF, 16'h1, 16'h1, REG_OPT, 16'hEFFE},
        '{CODE_RESOPT, 16'h00F1, 16'h1, 16'h1, REG_OPT, 16'h00F0},
        '{CODE_ERRLOG, 16'h0, 16'h1, 16'h1, REG_OPT, 16'h00F0},
        '{CODE_MODOPT, 16'h1111, 16'h0, 16'h2, REG_OPT, 16'h00F0},
        '{CODE_GRPHI, 16'h5678, 16'h0, 16'h2, REG_GRP, 16'h1235},
        '{CODE_BRIDGE, 16'h0, 16'h0, 16'h2, REG_SCODE, CODE_ERRLOG}};
    always #5 CLK_I = ~CLK_I;
    assign MEM_RDATA_I = MEM_ADDR_O ^ 16'hA5A5;
    ahch_cmd_handler ahch_cmd_handler_i (.*);
    ahch_host_model ahch_host_model_i (.clk_i(CLK_I), .req_i(DMA_REQ_O), .we_i(DMA_WE_O), .addr_i(DMA_ADDR_O),
        .wdata_i(DMA_WDATA_O), .rdata_o(DMA_RDATA_I), .ack_o(DMA_ACK_I));
    always @(posedge CLK_I) begin
        ev <= clr ? 4'h0 : ev | {FRM_REJ_O, ADP_CHK_O, CMD_REJ_O, CMD_DONE_O};
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {2'b10, w, a, d};
        @(posedge CLK_I);
        PENABLE_I <= 1;
        @(posedge CLK_I);
        while (PREADY_O !== 1'b1) @(posedge CLK_I);
        rd = PRDATA_O;
        err = PSLVERR_O;
        {PSEL_I, PENABLE_I} <= 2'b00;
    endtask
    task cmd(input logic [15:0] c, input logic [15:0] p0, input logic [15:0] p1);
        apb(1, REG_CMD, {16'h0, c});
        apb(1, REG_P0, {16'h0, p0});
        apb(1, REG_P1, {16'h0, p1});
        clr <= 1;
        @(posedge CLK_I);
        clr <= 0;
        apb(1, REG_ISSUE, 32'h0);
        repeat (400) if (ev == 4'h0) @(posedge CLK_I);
    endtask
    task stat(input logic [15:0] c, input logic [15:0] s);
        apb(0, REG_SCODE, 32'h0);
        chk(rd, {16'h0, c});
        apb(0, REG_SP0, 32'h0);
        chk(rd, {16'h0, s});
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CLK_I);
        RST_I <= 0;
        apb(0, REG_GRP, 32'h0);
        chk(rd, 32'hC000);
        apb(0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        // Option words of the open rows keep bit 12 and reserved bits clear
        for (int i = 0; i < 7; i++) begin
            OPEN_I <= rows[i][2][0];
            cmd(rows[i][0], rows[i][1], rows[i][0] == CODE_ERRLOG ? 16'h0080 : 16'h0);
            chk({28'h0, ev}, {16'h0, rows[i][3]});
            apb(0, rows[i][4][7:0], 32'h0);
            chk(rd, {16'h0, rows[i][5]});
            if (rows[i][3] == 16'h1) stat(rows[i][0], ST_GOOD);
        end
        chk({16'h0, ahch_host_model_i.mem[8'h46]}, 32'h1106);
        // Pointer area readout while still closed
        ahch_host_model_i.mem[8'h30:8'h33] = '{16'h4, 16'h8A00, 16'h2, 16'h8200};
        ahch_host_model_i.mem[8'h20:8'h27] = '{16'h4480, 16'h1, 16'h2, 16'h3, 16'h41C0, 16'h1, 16'h2, 16'h3};
        cmd(CODE_READ, 16'h0, 16'h0060);
        stat(CODE_READ, ST_GOOD);
        chk({16'h0, ahch_host_model_i.mem[8'h30]}, 32'hAFA5);
        cmd(CODE_READ, 16'h0, 16'h0064);
        chk({28'h0, ev}, 32'h4);
        OPEN_I <= 1;
        cmd(CODE_BRIDGE, 16'h0, 16'h0040);
        stat(CODE_BRIDGE, 16'h1);
        chk({31'h0, SRC_CHK_EN_O}, 32'h1);
        {FRM_VALID_I, FRM_BCAST_I} <= 2'b11;
        @(posedge CLK_I);
        FRM_VALID_I <= 0;
        repeat (2) @(posedge CLK_I);
        chk({31'h0, ev[3]}, 32'h1);
        {FRM_BCAST_I, FRM_LEN_I, FRM_SEG_IN_I, FRM_SEG_OUT_I} <= {1'b0, 6'h0A, 16'h0013, 16'h0020};
        FRM_VALID_I <= 1;
        @(posedge CLK_I);
        FRM_VALID_I <= 0;
        @(posedge CLK_I);
        chk({30'h0, FRM_FWD_O, FRM_REJ_O}, 32'h2);
        // Mid-run reset: checker off, options recaptured on open
        OPEN_OPT_I <= 16'h0040;
        RST_I <= 1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 0;
        repeat (2) @(posedge CLK_I);
        chk({31'h0, SRC_CHK_EN_O}, 32'h0);
        chk({16'h0, OPEN_OPT_O}, 32'h0040);
        chk({16'h0, GRP_HI_O}, 32'hC000);
        cmd(CODE_BRIDGE, 16'h0, 16'h0048);
        stat(CODE_BRIDGE, 16'h2);
        chk({31'h0, SRC_CHK_EN_O}, 32'h0);
        print_verdict();
    end
endmodule // adapter_host_command_handler_bench
`default_nettype wire
